// ===== core/rdt_regs.svh
// Register map, field positions, reset values and timing counts of the
// receive tracking loops. Assumes a 32-bit word per register.
`ifndef RDT_REGS_SVH
`define RDT_REGS_SVH
// Register index; the byte address is four times the index.
`define RDT_NREG 12
`define RDT_IX_FGAIN 4'h0
`define RDT_IX_FPER 4'h1
`define RDT_IX_FCTRL 4'h2
`define RDT_IX_GHI 4'h3
`define RDT_IX_GLO 4'h4
`define RDT_IX_GCTRL 4'h5
`define RDT_IX_TPOST 4'h6
`define RDT_IX_TGA 4'h7
`define RDT_IX_TGB 4'h8
`define RDT_IX_CHBW 4'h9
`define RDT_IX_RSTH 4'hA
`define RDT_IX_SINC 4'hB
`define RDT_IX_STAT 4'hC
// Field positions.
`define RDT_F_LO 3:0
`define RDT_F_HI 7:4
`define RDT_F_BYTE 7:0
`define RDT_F_EN 0
`define RDT_F_OPT 1
`define RDT_F_MOD 6:4
`define RDT_F_LOSEL 15:8
`define RDT_F_HOLD 13:8
`define RDT_F_P 2:0
`define RDT_F_I 6:4
`define RDT_F_INC 15:0
`define RDT_F_ATT 11:8
`define RDT_F_FSLOW 12
`define RDT_F_SYNC 13
`define RDT_F_SIG 14
// Writable bits of each register.
`define RDT_MSK_ALL {32'h0000FFFF, 32'h000000FF, 32'h000000FF, \
  32'h00000077, 32'h00000077, 32'h00000003, 32'h00003F03, \
  32'h0000FFFF, 32'h000000FF, 32'h00000073, 32'h000000FF, 32'h000000FF}
// Reset values, highest index first.
`define RDT_RST_ALL {32'h00001000, 32'h00000000, 32'h00000000, \
  32'h00000022, 32'h00000022, 32'h00000000, 32'h00000C00, \
  32'h00001045, 32'h00000025, 32'h00000000, 32'h00000010, 32'h00000032}
// Clock periods per gain-control tick, step limit, filter code limits.
`define RDT_AGC_TICKS 19'h0000C
`define RDT_ATT_MAX 4'h8
`define RDT_CH_MMAX 4'h8
`define RDT_CH_EMAX 4'h9
`endif

// ===== core/rdt_pkg.sv
// Types shared by the receive tracking loops.
// Assumes the register header is included by the modules that use it.
package rdt_pkg;
  typedef enum logic [2:0] {
    RDT_MOD_FSK2, RDT_MOD_FSK4, RDT_MOD_GFSK2, RDT_MOD_GFSK4,
    RDT_MOD_ASK, RDT_MOD_OOK
  } rdt_mod_e;
  typedef enum logic {RDT_AGC_HOLD, RDT_AGC_MEAS} rdt_agc_e;
  typedef struct packed {
    rdt_agc_e st;
    logic [18:0] cnt;
    logic [3:0] att;
  } rdt_agc_s;
  typedef struct packed {
    logic [11:0][31:0] cfg;
    logic wt;
    logic [31:0] rd;
    logic sig;
    logic sync;
    logic fslow;
    logic [7:0] fcnt;
    logic signed [15:0] est;
    logic [7:0] slc;
    logic [7:0] if2;
    logic [15:0] acc;
    logic signed [15:0] tfrq;
    logic tick;
  } rdt_top_s;
endpackage : rdt_pkg

// ===== core/rdt_agc_if.sv
// Settings and attenuation between the top and the gain controller.
// Assumes one clock domain on both sides.
`timescale 1ns/100ps
interface rdt_agc_if;
  logic en, frz, sync, restart;
  logic [3:0] hi, lo0, lo1, meas, amp, att;
  logic [7:0] sel;
  logic [5:0] hold;
  modport ctl(output en, frz, sync, restart, hi, lo0, lo1, sel, meas,
              hold, amp, input att);
  modport eng(input en, frz, sync, restart, hi, lo0, lo1, sel, meas,
              hold, amp, output att);
endinterface : rdt_agc_if

// ===== core/rdt_agc.sv
// Gain controller: steps RF attenuation from the peak amplitude.
// Assumes amplitude and settings synchronous to i_clk_sys.
`timescale 1ns/100ps
`include "rdt_regs.svh"
module rdt_agc (
  input logic i_clk_sys,
  input logic i_arst_n,
  rdt_agc_if.eng g
);
  rdt_pkg::rdt_agc_s s_r;
  rdt_pkg::rdt_agc_s s_nxt;
  logic [18:0] meas_len;
  logic [18:0] hold_len;
  logic [2:0] sidx;
  logic [3:0] lo;
  logic frozen;

  assign meas_len = `RDT_AGC_TICKS << g.meas; // [RULE_13]
  assign hold_len = `RDT_AGC_TICKS * {13'h0000, g.hold}; // [RULE_14]
  // Step 8 has no bit of its own and shares the last one.
  assign sidx = s_r.att[3] ? 3'h7 : s_r.att[2:0];
  assign lo = g.sel[sidx] ? g.lo1 : g.lo0; // [RULE_12]
  assign frozen = !g.en || (g.frz && g.sync); // [RULE_15] [RULE_16]
  assign g.att = s_r.att;

  always_comb begin
    s_nxt = s_r;
    if (g.restart) begin // [RULE_23]
      s_nxt.st = rdt_pkg::RDT_AGC_MEAS;
      s_nxt.cnt = 19'h00000;
      s_nxt.att = 4'h0;
    end else if (!frozen) begin
      case (s_r.st)
        rdt_pkg::RDT_AGC_HOLD: begin
          if (s_r.cnt <= 19'h00001) begin
            s_nxt.st = rdt_pkg::RDT_AGC_MEAS;
            s_nxt.cnt = 19'h00000;
          end else begin
            s_nxt.cnt = s_r.cnt - 19'h00001;
          end
        end
        rdt_pkg::RDT_AGC_MEAS: begin
          if (g.amp > g.hi) begin // [RULE_09] [RULE_11]
            s_nxt.cnt = 19'h00000;
            if (s_r.att < `RDT_ATT_MAX) begin // [RULE_08]
              s_nxt.att = s_r.att + 4'h1;
              s_nxt.st = rdt_pkg::RDT_AGC_HOLD;
              s_nxt.cnt = hold_len;
            end
          end else if (g.amp < lo) begin // [RULE_10]
            if (s_r.cnt >= meas_len - 19'h00001) begin
              s_nxt.cnt = 19'h00000;
              if (s_r.att != 4'h0) begin
                s_nxt.att = s_r.att - 4'h1;
                s_nxt.st = rdt_pkg::RDT_AGC_HOLD;
                s_nxt.cnt = hold_len;
              end
            end else begin
              s_nxt.cnt = s_r.cnt + 19'h00001;
            end
          end else begin
            s_nxt.cnt = 19'h00000;
          end
        end
        default: s_nxt.st = rdt_pkg::RDT_AGC_MEAS;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_r <= '{st: rdt_pkg::RDT_AGC_MEAS, cnt: 19'h00000, att: 4'h0};
    end else begin
      s_r <= s_nxt;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  property p_att_max;
    s_r.att <= `RDT_ATT_MAX;
  endproperty
  a_att_max: assert property (p_att_max) // [RULE_08]
    else $error("attenuation beyond 48 dB");
  property p_att_up;
    (s_r.st == rdt_pkg::RDT_AGC_MEAS && g.amp > g.hi && !frozen &&
     !g.restart && s_r.att < `RDT_ATT_MAX) |=> s_r.att == $past(s_r.att) + 4'h1;
  endproperty
  a_att_up: assert property (p_att_up) // [RULE_09]
    else $error("high amplitude did not raise attenuation");
  property p_hold;
    ($changed(s_r.att) && !$past(g.restart)) |->
      s_r.st == rdt_pkg::RDT_AGC_HOLD && s_r.cnt == $past(hold_len);
  endproperty
  a_hold: assert property (p_hold) // [RULE_14]
    else $error("attenuation change without hold time");
  property p_freeze;
    (g.frz && g.sync && !g.restart) |=> $stable(s_r.att);
  endproperty
  a_freeze: assert property (p_freeze) // [RULE_15]
    else $error("attenuation moved after sync freeze");
  property p_agc_en;
    (!g.en && !g.restart) |=> $stable(s_r.att) && $stable(s_r.cnt);
  endproperty
  a_agc_en: assert property (p_agc_en) // [RULE_16]
    else $error("gain control ran while disabled");
  c_att_down: cover property (s_r.att < $past(s_r.att) && !$past(g.restart));
endmodule : rdt_agc

// ===== core/rdt_loops.sv
// Receive tracking loops: frequency compensation, gain control and
// symbol timing recovery, with an Avalon-MM register slave.
// Assumes samples, levels and strobes synchronous to i_clk_sys.
//
// Contract
// RULE_01 - Frequency loop runs only for FSK modulations
// RULE_02 - Correction to slicer offset or second IF
// RULE_03 - Frequency error estimate readable by software
// RULE_04 - Fast gain after level threshold, then slow
// RULE_05 - Separate fast and slow log2 gains 0..15
// RULE_06 - Fast period counts samples; zero means sync
// RULE_07 - Frequency loop runs only while enabled
// RULE_08 - Attenuation steps of 6 dB up to 48
// RULE_09 - Above high threshold: step up each hold
// RULE_10 - Below low for whole measure: step down
// RULE_11 - High threshold programmable 0..15
// RULE_12 - Two low thresholds chosen per step
// RULE_13 - Measure time is 12 times two^exponent
// RULE_14 - Hold time 12 times value after change
// RULE_15 - Freeze-on-sync holds attenuation after sync
// RULE_16 - Gain loop runs only while enabled
// RULE_17 - Loop order: 0 first order, 1 second
// RULE_18 - Post-filter length bit, long when set
// RULE_19 - Timing recovery starts after level threshold
// RULE_20 - Proportional gains fast and slow 0..7
// RULE_21 - Second order: fast gains before sync, slow after
// RULE_22 - Bandwidth code mantissa 0..8, exponent 0..9
// RULE_23 - New reception restarts all loops in fast
`timescale 1ns/100ps
`include "rdt_regs.svh"
module rdt_loops (
  input logic i_clk_sys,
  input logic i_arst_n,
  input logic [5:0] i_avs_address,
  input logic i_avs_read,
  input logic i_avs_write,
  input logic [31:0] i_avs_writedata,
  input logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input logic i_rx_start,
  input logic i_sync_det,
  input logic [7:0] i_rssi,
  input logic i_smp_vld,
  input logic signed [7:0] i_freq_smp,
  input logic [3:0] i_amp_peak,
  input logic i_edge_vld,
  input logic signed [7:0] i_phase_err,
  output logic [7:0] o_slicer_offset,
  output logic [7:0] o_if2_offset,
  output logic [3:0] o_rf_atten,
  output logic o_sym_tick,
  output logic o_postfilt_long,
  output logic [3:0] o_chbw_mant,
  output logic [3:0] o_chbw_exp
);
  localparam logic [11:0][31:0] RST = `RDT_RST_ALL;
  localparam logic [11:0][31:0] MSK = `RDT_MSK_ALL;

  rdt_pkg::rdt_top_s s_r;
  rdt_pkg::rdt_top_s s_nxt;
  rdt_agc_if gi ();
  logic [3:0] idx;
  logic req;
  logic [31:0] rdv;
  logic [31:0] stat;
  logic fsk;
  logic afc_en;
  logic if2m;
  logic [7:0] per;
  logic run;
  logic [3:0] fgain;
  logic [2:0] kp;
  logic [2:0] ki;
  logic ord2;

  assign idx = i_avs_address[5:2];
  assign req = i_avs_read || i_avs_write;

  assign fsk = s_r.cfg[`RDT_IX_FCTRL][`RDT_F_MOD] <
               3'(rdt_pkg::RDT_MOD_ASK); // [RULE_01]
  assign afc_en = s_r.cfg[`RDT_IX_FCTRL][`RDT_F_EN]; // [RULE_07]
  assign if2m = s_r.cfg[`RDT_IX_FCTRL][`RDT_F_OPT];
  assign per = s_r.cfg[`RDT_IX_FPER][`RDT_F_BYTE];
  assign run = fsk && afc_en && s_r.sig; // [RULE_01] [RULE_04] [RULE_07]
  assign fgain = s_r.fslow ? s_r.cfg[`RDT_IX_FGAIN][`RDT_F_HI]
                           : s_r.cfg[`RDT_IX_FGAIN][`RDT_F_LO]; // [RULE_05]
  assign ord2 = s_r.cfg[`RDT_IX_TPOST][`RDT_F_OPT]; // [RULE_17]
  // Post-sync gains apply in both orders; only the second has ki.
  assign kp = s_r.sync ? s_r.cfg[`RDT_IX_TGB][`RDT_F_P]
                       : s_r.cfg[`RDT_IX_TGA][`RDT_F_P]; // [RULE_20] [RULE_21]
  assign ki = s_r.sync ? s_r.cfg[`RDT_IX_TGB][`RDT_F_I]
                       : s_r.cfg[`RDT_IX_TGA][`RDT_F_I]; // [RULE_21]

  assign gi.en = s_r.cfg[`RDT_IX_GCTRL][`RDT_F_EN];
  assign gi.frz = s_r.cfg[`RDT_IX_GCTRL][`RDT_F_OPT];
  assign gi.sync = s_r.sync;
  assign gi.restart = i_rx_start;
  assign gi.hi = s_r.cfg[`RDT_IX_GHI][`RDT_F_LO];
  assign gi.meas = s_r.cfg[`RDT_IX_GHI][`RDT_F_HI];
  assign gi.lo0 = s_r.cfg[`RDT_IX_GLO][`RDT_F_LO];
  assign gi.lo1 = s_r.cfg[`RDT_IX_GLO][`RDT_F_HI];
  assign gi.sel = s_r.cfg[`RDT_IX_GLO][`RDT_F_LOSEL];
  assign gi.hold = s_r.cfg[`RDT_IX_GCTRL][`RDT_F_HOLD];
  assign gi.amp = i_amp_peak;

  rdt_agc u_agc (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .g(gi.eng)
  );

  always_comb begin
    stat = 32'h00000000;
    stat[`RDT_F_BYTE] = s_r.est[15:8]; // [RULE_03]
    stat[`RDT_F_ATT] = gi.att;
    stat[`RDT_F_FSLOW] = s_r.fslow;
    stat[`RDT_F_SYNC] = s_r.sync;
    stat[`RDT_F_SIG] = s_r.sig;
    if (idx < 4'(`RDT_NREG)) begin
      rdv = s_r.cfg[idx];
    end else if (idx == `RDT_IX_STAT) begin
      rdv = stat;
    end else begin
      rdv = 32'h00000000;
    end
  end

  always_comb begin
    logic [31:0] wm;
    logic signed [16:0] dif;
    logic signed [15:0] e;
    logic [16:0] sum;
    logic [15:0] inc;
    wm = 32'h00000000;
    dif = 17'h00000;
    e = 16'h0000;
    sum = 17'h00000;
    inc = 16'h0000;
    s_nxt = s_r;

    // One wait cycle, then the answer with waitrequest low.
    s_nxt.wt = !(req && s_r.wt);
    if (i_avs_read && s_r.wt) begin
      s_nxt.rd = rdv;
    end
    if (i_avs_write && !s_r.wt && idx < 4'(`RDT_NREG)) begin
      wm = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
            {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
      wm = wm & MSK[idx];
      s_nxt.cfg[idx] = (s_r.cfg[idx] & ~wm) | (i_avs_writedata & wm);
    end
    // Codes beyond the table saturate to its last row or column.
    if (s_nxt.cfg[`RDT_IX_CHBW][`RDT_F_LO] > `RDT_CH_MMAX) begin
      s_nxt.cfg[`RDT_IX_CHBW][`RDT_F_LO] = `RDT_CH_MMAX; // [RULE_22]
    end
    if (s_nxt.cfg[`RDT_IX_CHBW][`RDT_F_HI] > `RDT_CH_EMAX) begin
      s_nxt.cfg[`RDT_IX_CHBW][`RDT_F_HI] = `RDT_CH_EMAX; // [RULE_22]
    end

    s_nxt.tick = 1'b0;
    if (i_rx_start) begin // [RULE_23]
      s_nxt.sig = 1'b0;
      s_nxt.sync = 1'b0;
      s_nxt.fslow = 1'b0;
      s_nxt.fcnt = 8'h00;
      s_nxt.est = 16'h0000;
      s_nxt.acc = 16'h0000;
      s_nxt.tfrq = 16'h0000;
    end else begin
      if (i_rssi > s_r.cfg[`RDT_IX_RSTH][`RDT_F_BYTE]) begin
        s_nxt.sig = 1'b1; // [RULE_04] [RULE_19]
      end
      if (i_sync_det) begin
        s_nxt.sync = 1'b1;
      end
      if (run && per == 8'h00 && i_sync_det) begin
        s_nxt.fslow = 1'b1; // [RULE_06]
      end
      if (run && i_smp_vld) begin
        // Mean of the demodulated frequency is the DC offset.
        dif = 17'(signed'({i_freq_smp, 8'h00})) - 17'(s_r.est);
        s_nxt.est = s_r.est + 16'(dif >>> fgain); // [RULE_05]
        if (per != 8'h00 && !s_r.fslow) begin
          s_nxt.fcnt = s_r.fcnt + 8'h01;
          if (s_r.fcnt + 8'h01 >= per) begin
            s_nxt.fslow = 1'b1; // [RULE_04] [RULE_06]
          end
        end
      end
      if (s_r.sig) begin // [RULE_19]
        inc = s_r.cfg[`RDT_IX_SINC][`RDT_F_INC];
        if (ord2) begin
          inc = inc + s_r.tfrq; // [RULE_17]
        end
        sum = {1'b0, s_r.acc} + {1'b0, inc};
        s_nxt.tick = sum[16];
        s_nxt.acc = sum[15:0];
        if (i_edge_vld) begin
          e = 16'(i_phase_err);
          s_nxt.acc = sum[15:0] - 16'(e >>> kp); // [RULE_20]
          if (ord2) begin
            s_nxt.tfrq = s_r.tfrq - (e >>> ki); // [RULE_21]
          end
        end
      end
    end
    // Only one path carries the correction at a time.
    if (if2m) begin // [RULE_02]
      s_nxt.slc = 8'h00;
      s_nxt.if2 = s_nxt.est[15:8];
    end else begin
      s_nxt.slc = s_nxt.est[15:8];
      s_nxt.if2 = 8'h00;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_r <= '{cfg: RST, wt: 1'b1, rd: 32'h00000000, sig: 1'b0,
               sync: 1'b0, fslow: 1'b0, fcnt: 8'h00, est: 16'h0000,
               slc: 8'h00, if2: 8'h00, acc: 16'h0000, tfrq: 16'h0000,
               tick: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_avs_readdata = s_r.rd;
  assign o_avs_waitrequest = s_r.wt;
  assign o_slicer_offset = s_r.slc;
  assign o_if2_offset = s_r.if2;
  assign o_rf_atten = gi.att; // [RULE_08]
  assign o_sym_tick = s_r.tick;
  assign o_postfilt_long = s_r.cfg[`RDT_IX_TPOST][`RDT_F_EN]; // [RULE_18]
  assign o_chbw_mant = s_r.cfg[`RDT_IX_CHBW][`RDT_F_LO]; // [RULE_22]
  assign o_chbw_exp = s_r.cfg[`RDT_IX_CHBW][`RDT_F_HI];

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  property p_fm_only;
    (!fsk && !i_rx_start) |=> $stable(s_r.est);
  endproperty
  a_fm_only: assert property (p_fm_only) // [RULE_01]
    else $error("frequency loop moved without FSK");
  property p_route;
    !if2m |=> o_if2_offset == 8'h00 && o_slicer_offset == s_r.est[15:8];
  endproperty
  a_route: assert property (p_route) // [RULE_02]
    else $error("slicer mode correction misrouted");
  property p_est_read;
    (i_avs_read && s_r.wt && idx == `RDT_IX_STAT) |=>
      o_avs_readdata[7:0] == $past(s_r.est[15:8]) && !o_avs_waitrequest;
  endproperty
  a_est_read: assert property (p_est_read) // [RULE_03]
    else $error("status read lost the frequency estimate");
  property p_fast_start;
    i_rx_start |=> !s_r.fslow && s_r.est == 16'h0000 && o_rf_atten == 4'h0;
  endproperty
  a_fast_start: assert property (p_fast_start) // [RULE_04]
    else $error("new reception did not restart loops");
  property p_sync_switch;
    (run && per == 8'h00 && i_sync_det && !i_rx_start) |=> s_r.fslow;
  endproperty
  a_sync_switch: assert property (p_sync_switch) // [RULE_06]
    else $error("zero fast period missed the sync switch");
  property p_count_switch;
    (run && i_smp_vld && per != 8'h00 && !s_r.fslow &&
     s_r.fcnt + 8'h01 < per && !i_sync_det && !i_rx_start) |=> !s_r.fslow;
  endproperty
  a_count_switch: assert property (p_count_switch) // [RULE_06]
    else $error("slow mode entered before fast period ended");
  property p_afc_en;
    (!afc_en && !i_rx_start) |=> $stable(s_r.est) && $stable(s_r.fslow);
  endproperty
  a_afc_en: assert property (p_afc_en) // [RULE_07]
    else $error("frequency loop ran while disabled");
  property p_str_gate;
    (!s_r.sig && !i_rx_start) |=> $stable(s_r.acc) && !o_sym_tick;
  endproperty
  a_str_gate: assert property (p_str_gate) // [RULE_19]
    else $error("timing recovery ran below signal threshold");
  property p_ord1;
    (!ord2 && !i_rx_start) |=> $stable(s_r.tfrq);
  endproperty
  a_ord1: assert property (p_ord1) // [RULE_17]
    else $error("first order loop changed its frequency term");
  property p_chbw;
    o_chbw_mant <= `RDT_CH_MMAX && o_chbw_exp <= `RDT_CH_EMAX;
  endproperty
  a_chbw: assert property (p_chbw) // [RULE_22]
    else $error("channel filter code out of table");
  property p_bus;
    (req && s_r.wt) |=> !o_avs_waitrequest ##1 o_avs_waitrequest;
  endproperty
  a_bus: assert property (p_bus)
    else $error("bus answer not one cycle after request");

  property p_if2_route;
    if2m |=> o_slicer_offset == 8'h00 && o_if2_offset == s_r.est[15:8];
  endproperty
  a_if2_route: assert property (p_if2_route) // [RULE_02]
    else $error("second IF mode correction misrouted");
  // A restart must leave no trace of the previous attempt in any loop.
  property p_restart;
    i_rx_start |=> !s_r.sig && !s_r.sync && s_r.acc == 16'h0000 &&
      s_r.tfrq == 16'h0000 && s_r.fcnt == 8'h00;
  endproperty
  a_restart: assert property (p_restart) // [RULE_23]
    else $error("new reception left loop state behind");
  // With a fast gain of zero the estimate jumps to the sample itself.
  property p_fast_exact;
    (run && i_smp_vld && !s_r.fslow && !i_rx_start &&
     s_r.cfg[`RDT_IX_FGAIN][`RDT_F_LO] == 4'h0) |=>
      s_r.est == {$past(i_freq_smp), 8'h00};
  endproperty
  a_fast_exact: assert property (p_fast_exact) // [RULE_05]
    else $error("fast gain did not set the estimate");
  property p_slow_kept;
    (s_r.fslow && !i_rx_start) |=> s_r.fslow;
  endproperty
  a_slow_kept: assert property (p_slow_kept) // [RULE_04]
    else $error("slow mode left without a new reception");
  // Before sync a zero integral shift passes the whole error on.
  property p_presync_int;
    (ord2 && s_r.sig && !s_r.sync && i_edge_vld && !i_rx_start &&
     s_r.cfg[`RDT_IX_TGA][`RDT_F_I] == 3'h0) |=>
      s_r.tfrq == $past(s_r.tfrq) - 16'($past(i_phase_err));
  endproperty
  a_presync_int: assert property (p_presync_int) // [RULE_21]
    else $error("pre-sync integral gain not applied");
  property p_sig_start;
    (!i_rx_start && i_rssi > s_r.cfg[`RDT_IX_RSTH][`RDT_F_BYTE]) |=>
      s_r.sig;
  endproperty
  a_sig_start: assert property (p_sig_start) // [RULE_19]
    else $error("signal above threshold did not start the loops");

  c_fslow: cover property ($rose(s_r.fslow));
  c_tick: cover property (o_sym_tick && ord2 && s_r.sync);
  c_att: cover property ($rose(o_rf_atten != 4'h0));
  c_write: cover property (i_avs_write && !o_avs_waitrequest);
endmodule : rdt_loops

// ===== verification/rdt_front_end.sv
// Front-end model: RF attenuator, IF ADC peak detector and level meter.
// Assumes the attenuation from the loops and a test level from the bench.
`timescale 1ns/100ps
module rdt_front_end (
  input logic i_clk_sys,
  input logic i_arst_n,
  input logic [3:0] i_lvl,
  input logic [3:0] i_att,
  output logic [3:0] o_amp_peak,
  output logic [7:0] o_rssi
);
  // One cycle of converter latency, so every step is seen one cycle late.
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_amp_peak <= 4'h0;
      o_rssi <= 8'h00;
    end else begin
      o_amp_peak <= (i_lvl > i_att) ? i_lvl - i_att : 4'h0;
      o_rssi <= {i_lvl, 4'h0};
    end
  end
endmodule : rdt_front_end

// ===== verification/test_rdt_loops.sv
// Self-checking bench of the receive tracking loops.
// Assumes the front-end model beside it and core/ on the include path.
`timescale 1ns/100ps
`include "rdt_regs.svh"
module test_rdt_loops;
  localparam logic [11:0][31:0] RST = `RDT_RST_ALL;
  localparam logic [11:0][31:0] MSK = `RDT_MSK_ALL;
  logic clk = 1'b0, arst_n = 1'b0, rd_en = 1'b0, wr_en = 1'b0;
  logic rx_start = 1'b0, sync = 1'b0, smp_vld = 1'b0, edge_vld = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [31:0] wdat = 32'h00000000, seed = 32'h25CD5428, q, rdat;
  logic [7:0] smp = 8'h00, rssi, slc, if2;
  logic [3:0] lvl = 4'h0, amp, att, mant, expo;
  logic wreq, tick, pfl, run;
  int fails = 0, checked = 0, cyc = 0, n, w;

  rdt_loops i_rdt_loops (
    .i_clk_sys(clk), .i_arst_n(arst_n), .i_avs_address(adr),
    .i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wdat),
    .i_avs_byteenable(4'hF), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wreq), .i_rx_start(rx_start), .i_sync_det(sync),
    .i_rssi(rssi), .i_smp_vld(smp_vld), .i_freq_smp(smp),
    .i_amp_peak(amp), .i_edge_vld(edge_vld), .i_phase_err(8'h40),
    .o_slicer_offset(slc), .o_if2_offset(if2), .o_rf_atten(att),
    .o_sym_tick(tick), .o_postfilt_long(pfl), .o_chbw_mant(mant),
    .o_chbw_exp(expo));

  rdt_front_end i_rdt_front_end (
    .i_clk_sys(clk), .i_arst_n(arst_n), .i_lvl(lvl), .i_att(att),
    .o_amp_peak(amp), .o_rssi(rssi));

  always #12.5 clk = ~clk;

  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  task automatic rng(input string nm, input int lo, input int hi,
      input int g);
    checked++;
    if (g < lo || g > hi) begin
      fails++;
      $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : rng

  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    for (int k = 0; k < 8; k++) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    return s;
  endfunction : lfsr

  function automatic logic [3:0] clamp(input logic [3:0] v,
      input logic [3:0] mx);
    return (v > mx) ? mx : v;
  endfunction : clamp

  // Called just after a rising edge; the request is held until the edge
  // that sees waitrequest low, and one idle cycle follows the release.
  task automatic bus(input logic wr, input logic [3:0] ix,
      input logic [31:0] d, output logic [31:0] r);
    adr <= {ix, 2'b00};
    wr_en <= wr;
    rd_en <= !wr;
    wdat <= d;
    @(posedge clk);
    while (wreq !== 1'b0) @(posedge clk);
    r = rdat;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic wr(input logic [3:0] ix, input logic [31:0] d);
    bus(1'b1, ix, d, q);
  endtask : wr

  task automatic rdchk(input string nm, input logic [3:0] ix,
      input logic [31:0] e);
    bus(1'b0, ix, 32'h00000000, q);
    chk(nm, e, q);
  endtask : rdchk

  task automatic pls(input logic s);
    if (s) sync <= 1'b1;
    else rx_start <= 1'b1;
    @(posedge clk);
    sync <= 1'b0;
    rx_start <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : pls

  task automatic send(input logic [7:0] s);
    smp <= s;
    smp_vld <= 1'b1;
    @(posedge clk);
    smp_vld <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : send

  task automatic watt(input logic [3:0] a);
    w = 0;
    while (att !== a) begin
      @(posedge clk);
      w++;
    end
  endtask : watt

  task automatic cnt(input int len, input logic e);
    n = 0;
    for (int c = 0; c < len; c++) begin
      edge_vld <= e && (c % 16 == 8);
      @(posedge clk);
      if (tick === 1'b1) n++;
    end
    edge_vld <= 1'b0;
  endtask : cnt

  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 16; i++)
      rdchk("reset value", i[3:0], i < 12 ? RST[i] : 32'h0);
    for (int i = 0; i < 16; i++) wr(i[3:0], 32'hFFFFFFFF);
    chk("long filter", 32'h1, 32'(pfl));
    for (int i = 0; i < 16; i++)
      rdchk("write mask", i[3:0], i == 9 ? 32'h98 :
        (i < 12 ? MSK[i] : 32'h0));
    for (int i = 0; i < 12; i++) wr(i[3:0], RST[i]);
    chk("short filter", 32'h0, 32'(pfl));
    repeat (6) begin
      seed = lfsr(seed);
      wr(`RDT_IX_CHBW, 32'(seed[7:0]));
      chk("mantissa", 32'(clamp(seed[3:0], 4'h8)), 32'(mant));
      chk("exponent", 32'(clamp(seed[7:4], 4'h9)), 32'(expo));
    end
    // Fast gain 0 makes the estimate equal the last sample exactly.
    wr(`RDT_IX_FGAIN, 32'hF0);
    wr(`RDT_IX_FPER, 32'h3);
    wr(`RDT_IX_RSTH, 32'h40);
    lvl <= 4'hF;
    for (int m = 0; m < 18; m++) begin
      wr(`RDT_IX_FCTRL, 32'((m % 6) * 16 + (m / 6 == 1) * 2 + (m / 6 != 2)));
      pls(1'b0);
      seed = lfsr(seed);
      send(seed[7:0]);
      run = (m % 6 < 4) && (m / 6 != 2);
      chk("slicer", 32'(run && m < 6 ? seed[7:0] : 8'h0), 32'(slc));
      chk("second IF", 32'(run && m / 6 == 1 ? seed[7:0] : 8'h0), 32'(if2));
      rdchk("status", `RDT_IX_STAT, 32'h4000 | (run ? seed[7:0] : 8'h0));
    end
    wr(`RDT_IX_FCTRL, 32'h1);
    pls(1'b0);
    send(8'h10);
    send(8'h20);
    rdchk("fast phase", `RDT_IX_STAT, 32'h4020);
    send(8'h30);
    rdchk("slow phase", `RDT_IX_STAT, 32'h5030);
    send(8'h70);
    chk("slow gain", 32'h30, 32'(slc));
    wr(`RDT_IX_FPER, 32'h0);
    pls(1'b0);
    repeat (5) send(8'h44);
    bus(1'b0, `RDT_IX_STAT, 32'h0, q);
    chk("fast until sync", 32'h0, 32'(q[13:12]));
    pls(1'b1);
    bus(1'b0, `RDT_IX_STAT, 32'h0, q);
    chk("slow after sync", 32'h3, 32'(q[13:12]));
    lvl <= 4'h0;
    repeat (3) @(posedge clk);
    pls(1'b0);
    send(8'h55);
    rdchk("no signal", `RDT_IX_STAT, 32'h0);
    wr(`RDT_IX_FCTRL, 32'h0);
    wr(`RDT_IX_GLO, 32'hFF25);
    wr(`RDT_IX_GCTRL, 32'h201);
    lvl <= 4'hF;
    pls(1'b0);
    for (int a = 1; a < 9; a++) begin
      watt(a[3:0]);
      if (a > 1) rng("rise gap", 24, 26, w);
    end
    repeat (200) @(posedge clk);
    chk("ceiling", 32'h8, 32'(att));
    lvl <= 4'hC;
    repeat (300) @(posedge clk);
    chk("low one", 32'h8, 32'(att));
    wr(`RDT_IX_GLO, 32'h25);
    repeat (300) @(posedge clk);
    chk("low zero", 32'h7, 32'(att));
    lvl <= 4'h0;
    for (int a = 6; a >= 0; a--) begin
      watt(a[3:0]);
      if (a < 6) rng("fall gap", 72, 75, w);
    end
    wr(`RDT_IX_GCTRL, 32'h200);
    lvl <= 4'hF;
    repeat (200) @(posedge clk);
    chk("gain off", 32'h0, 32'(att));
    wr(`RDT_IX_GCTRL, 32'h202);
    pls(1'b1);
    wr(`RDT_IX_GCTRL, 32'h203);
    repeat (200) @(posedge clk);
    chk("frozen", 32'h0, 32'(att));
    pls(1'b0);
    repeat (100) @(posedge clk);
    rng("thawed", 2, 8, 32'(att));
    lvl <= 4'h0;
    repeat (3) @(posedge clk);
    pls(1'b0);
    chk("restart", 32'h0, 32'(att));
    wr(`RDT_IX_GCTRL, 32'h0);
    wr(`RDT_IX_TGA, 32'h07);
    wr(`RDT_IX_TGB, 32'h77);
    pls(1'b0);
    cnt(200, 1'b1);
    chk("ticks idle", 32'h0, 32'(n));
    lvl <= 4'hF;
    pls(1'b0);
    cnt(320, 1'b1);
    chk("first order", 32'd20, 32'(n));
    wr(`RDT_IX_TPOST, 32'h2);
    pls(1'b0);
    cnt(320, 1'b1);
    rng("second order", 0, 19, n);
    pls(1'b0);
    pls(1'b1);
    cnt(320, 1'b1);
    chk("after sync", 32'd20, 32'(n));
    conclude();
  end
endmodule : test_rdt_loops
